// File: design/iet_top.sv
// Interrupt enable, threshold, claim and completion block with APB slave.
// Assumes one clock, sources driven by same-clock logic, one hart target.
//
// Function
// RULE_01 - A source is deliverable only while its enable bit is one.
// RULE_02 - Enable bits pack ID N at bit N mod 32 of word N/32.
// RULE_03 - Enable bit of ID 0 reads zero and ignores writes.
// RULE_04 - Software uses only full 32-bit word accesses to enable words.
// RULE_05 - Enables reach ID 52 at high word bit 20; bits 31:21 read zero.
// RULE_06 - Threshold is three read-write bits 2:0; upper bits read zero.
// RULE_07 - Threshold accepts any write and reads back legal values up to 7.
// RULE_08 - Priorities at or below threshold are masked; 7 masks all.
// RULE_09 - Claim read returns highest-priority pending ID, or zero if none.
// RULE_10 - A nonzero claim clears that source's pending bit atomically.
// RULE_11 - Claim works at any time, regardless of the hart pending flag.
// RULE_12 - Claim selection ignores the threshold.
// RULE_13 - Software writes the claimed ID back to signal completion.
// RULE_14 - Completion is not checked against the last claimed ID.
// RULE_15 - Completion of a source not enabled is silently dropped.
// RULE_16 - Priority 7 highest, 0 never interrupts, ties go to lower ID.
// RULE_17 - Pending bits sit in two words, ID N at bit N mod 32, bit 0 zero.
// RULE_18 - Fifty-two level-triggered source lines, active high.
// RULE_19 - Claim considers only enabled sources of nonzero priority.
// RULE_20 - External request is high while best eligible priority beats threshold.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module iet_top (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire iet_pkg::iet_apb_req_t     apb_req,
  output iet_pkg::iet_apb_rsp_t          apb_rsp,
  input  wire logic [iet_pkg::IET_NUM_SRC:1] src_level,
  output logic                           machine_external_pending_flag
);
  import iet_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [IET_NUM_SRC:1]    en_q;
  logic [IET_PRIO_W-1:0]   prio_q [1:IET_NUM_SRC];
  logic [IET_PRIO_W-1:0]   thresh_q;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    irq_q;

  logic [IET_NUM_SRC:1]    pend;
  logic [IET_NUM_SRC-1:0]  elig;
  logic [IET_NUM_SRC*IET_PRIO_W-1:0] prio_flat;
  logic [IET_ID_W-1:0]     best_id;
  logic [IET_PRIO_W-1:0]   best_prio;
  logic                    best_valid;

  logic                    acc_first;
  logic                    wr_fire;
  logic                    claim_fire;
  logic                    complete_fire;
  logic                    prio_sel;
  logic [IET_ID_W-1:0]     prio_idx;
  logic [31:0]             rd_d;
  logic                    hit_d;
  logic [IET_ID_W-1:0]     done_id;

  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  // Every access has one wait state, so read data and the claim side
  // effect come from one registered sample and stay consistent.
  assign acc_first     = apb_req.psel && apb_req.penable && !pready_q;
  assign wr_fire       = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite;
  assign claim_fire    = acc_first && !apb_req.pwrite && (apb_req.paddr == IET_CLAIM)
                         && best_valid; // RULE_11
  // An ID wider than the field names no source, so its upper bits must not alias one.
  assign complete_fire = wr_fire && (apb_req.paddr == IET_CLAIM) && (apb_req.pwdata[31:IET_ID_W] == '0);
  assign done_id       = apb_req.pwdata[IET_ID_W-1:0];
  assign prio_idx      = apb_req.paddr[IET_IDX_MSB:IET_IDX_LSB];
  assign prio_sel      = (apb_req.paddr[31:IET_IDX_MSB+1] == IET_PRIO_BASE[31:IET_IDX_MSB+1])
                         && (apb_req.paddr[IET_IDX_LSB-1:0] == '0)
                         && (prio_idx != '0)
                         && (32'(prio_idx) <= 32'(IET_NUM_SRC));

  // ----------------------------------------------------------------------
  // Sources and selection
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g <= IET_NUM_SRC; g++) begin : gen_src
      logic done_hit;
      // The completed ID is compared with nothing but the enables.
      assign done_hit = complete_fire && (done_id == IET_ID_W'(g)) && en_q[g]; // RULE_14 RULE_15
      iet_gate u_gate (
        .clk          (clk),
        .reset_n      (reset_n),
        .src_level    (src_level[g]),
        .claim_hit    (claim_fire && (best_id == IET_ID_W'(g))),
        .complete_hit (done_hit),
        .pending      (pend[g])
      );
      assign elig[g-1] = pend[g] && en_q[g] && (prio_q[g] != '0); // RULE_01 RULE_19
      assign prio_flat[(g-1)*IET_PRIO_W +: IET_PRIO_W] = prio_q[g];
    end
  endgenerate

  iet_pick #(
    .N  (IET_NUM_SRC),
    .PW (IET_PRIO_W),
    .IW (IET_ID_W)
  ) u_pick (
    .elig       (elig),
    .prio_flat  (prio_flat),
    .best_id    (best_id),
    .best_prio  (best_prio),
    .best_valid (best_valid)
  );

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always_comb begin
    rd_d  = '0;
    hit_d = 1'b1;
    if (prio_sel) begin
      rd_d = 32'(prio_q[prio_idx]);
    end else begin
      case (apb_req.paddr)
        IET_PEND_LO: rd_d = {pend[IET_WORD_BITS-1:1], 1'b0}; // RULE_17
        IET_PEND_HI: rd_d = 32'(pend[IET_NUM_SRC:IET_WORD_BITS]);
        IET_EN_LO:   rd_d = {en_q[IET_WORD_BITS-1:1], 1'b0}; // RULE_02 RULE_03
        IET_EN_HI:   rd_d = 32'(en_q[IET_NUM_SRC:IET_WORD_BITS]); // RULE_05
        IET_THRESH:  rd_d = 32'(thresh_q); // RULE_06
        IET_CLAIM:   rd_d = 32'(best_id); // RULE_09 RULE_12
        default:     hit_d = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first && !hit_d;
    end
  end

  // Writes to unmapped space are dropped; reads there return zero.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= '0;
    end else if (acc_first) begin
      prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_q <= IET_EN_RST;
    end else if (wr_fire && (apb_req.paddr == IET_EN_LO)) begin
      en_q[IET_WORD_BITS-1:1] <= apb_req.pwdata[IET_WORD_BITS-1:1]; // RULE_02 RULE_03
    end else if (wr_fire && (apb_req.paddr == IET_EN_HI)) begin
      en_q[IET_NUM_SRC:IET_WORD_BITS] <= apb_req.pwdata[IET_HI_BITS-1:0]; // RULE_05
    end
  end

  // Every three-bit value is legal, so the field is stored as written.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thresh_q <= IET_THRESH_RST;
    end else if (wr_fire && (apb_req.paddr == IET_THRESH)) begin
      thresh_q <= apb_req.pwdata[IET_THR_MSB:0]; // RULE_07
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int k = 1; k <= IET_NUM_SRC; k++) begin
        prio_q[k] <= IET_PRIO_RST;
      end
    end else if (wr_fire && prio_sel) begin
      prio_q[prio_idx] <= apb_req.pwdata[IET_PRIO_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Hart request
  // ----------------------------------------------------------------------
  // The best eligible priority is the maximum, so one compare covers all.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= best_valid && (best_prio > thresh_q); // RULE_08 RULE_20
    end
  end

  assign machine_external_pending_flag = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [IET_ID_W-1:0] claimed_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      claimed_q <= '0;
    end else if (claim_fire) begin
      claimed_q <= best_id;
    end
  end

  sequence s_claim_read;
    acc_first && !apb_req.pwrite && (apb_req.paddr == IET_CLAIM);
  endsequence

  sequence s_read_of(logic [31:0] a);
    acc_first && !apb_req.pwrite && (apb_req.paddr == a);
  endsequence

  sequence s_write_of(logic [31:0] a);
    wr_fire && (apb_req.paddr == a);
  endsequence

  a_bus_waitstate: assert property (@(posedge clk) disable iff (!reset_n)
    acc_first |=> pready_q ##1 !pready_q)
    else $error("Access did not complete after one wait state.");

  a_id0_enable: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    s_read_of(IET_EN_LO) |=> (prdata_q[0] == 1'b0))
    else $error("Enable bit of ID 0 read as one.");

  a_enhi_reserved: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    s_read_of(IET_EN_HI) |=> (prdata_q[31:IET_HI_BITS] == '0))
    else $error("Reserved enable bits read nonzero.");

  a_thresh_readback: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    s_read_of(IET_THRESH) |=> (prdata_q[IET_THR_MSB:0] == $past(thresh_q)))
    else $error("Threshold readback differs from stored field.");

  a_thresh_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    s_write_of(IET_THRESH) |=> (thresh_q == $past(apb_req.pwdata[IET_THR_MSB:0])))
    else $error("Threshold write did not store the low field.");

  a_thr_reserved: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    s_read_of(IET_THRESH) |=> (prdata_q[31:IET_THR_MSB+1] == '0))
    else $error("Reserved threshold bits read nonzero.");

  a_pend_id0: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
    s_read_of(IET_PEND_LO) |=> (prdata_q[0] == 1'b0))
    else $error("Pending bit of ID 0 read as one.");

  a_pendhi_reserved: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
    s_read_of(IET_PEND_HI) |=> (prdata_q[31:IET_HI_BITS] == '0))
    else $error("Reserved pending bits read nonzero.");

  a_enlo_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    s_write_of(IET_EN_LO) |=> (en_q[IET_WORD_BITS-1:1] == $past(apb_req.pwdata[IET_WORD_BITS-1:1])))
    else $error("Low enable word write did not land.");

  a_enhi_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    s_write_of(IET_EN_HI) |=> (en_q[IET_NUM_SRC:IET_WORD_BITS] == $past(apb_req.pwdata[IET_HI_BITS-1:0])))
    else $error("High enable word write did not land.");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    (en_q == '0)[*2] |-> !irq_q)
    else $error("Request raised with every source disabled.");

  a_claim_masked: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    (s_claim_read ##0 (best_valid && (best_prio <= thresh_q))) |=> (prdata_q != '0))
    else $error("Source masked by threshold was not claimable.");

  a_claim_empty: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    (s_claim_read and !best_valid) |=> (prdata_q == '0))
    else $error("Empty claim returned nonzero ID.");

  a_claim_clears: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    claim_fire |=> ##1 !pend[claimed_q])
    else $error("Claimed source still pending.");

  a_pick_eligible: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
    best_valid |-> (pend[best_id] && en_q[best_id] && (prio_q[best_id] == best_prio)))
    else $error("Selected source is not eligible.");

  a_mask_all: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    (thresh_q == IET_THRESH_MAX)[*2] |-> !irq_q)
    else $error("Request raised with full threshold mask.");

  a_irq_cause: assert property (@(posedge clk) disable iff (!reset_n) // RULE_20
    $rose(irq_q) |-> $past(best_valid && (best_prio > thresh_q)))
    else $error("Request rose without an eligible source above threshold.");

endmodule
`default_nettype wire

// File: design/iet_pkg.sv
// Package for the interrupt enable, threshold and claim block.
// Assumes a single 40 MHz clock and an APB register bus with 32-bit data.
package iet_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int IET_NUM_SRC   = 52;
  localparam int IET_ID_W      = 6;
  localparam int IET_PRIO_W    = 3;
  localparam int IET_WORD_BITS = 32;
  localparam int IET_HI_BITS   = IET_NUM_SRC - IET_WORD_BITS + 1;
  localparam int IET_IDX_LSB   = 2;
  localparam int IET_IDX_MSB   = 7;
  localparam int IET_THR_MSB   = 2;

  // --------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------
  localparam logic [31:0] IET_PRIO_BASE = 32'h0c00_0000;
  localparam logic [31:0] IET_PEND_LO   = 32'h0c00_1000;
  localparam logic [31:0] IET_PEND_HI   = 32'h0c00_1004;
  localparam logic [31:0] IET_EN_LO     = 32'h0c00_2000;
  localparam logic [31:0] IET_EN_HI     = 32'h0c00_2004;
  localparam logic [31:0] IET_THRESH    = 32'h0c20_0000;
  localparam logic [31:0] IET_CLAIM     = 32'h0c20_0004;

  // --------------------------------------------------------------------
  // Reset values and limits
  // --------------------------------------------------------------------
  localparam logic [IET_PRIO_W-1:0] IET_PRIO_RST   = 3'h0;
  localparam logic [IET_PRIO_W-1:0] IET_THRESH_RST = 3'h0;
  localparam logic [IET_PRIO_W-1:0] IET_THRESH_MAX = 3'h7;
  localparam logic [IET_NUM_SRC:1]  IET_EN_RST     = '0;

  // --------------------------------------------------------------------
  // Bus carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } iet_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } iet_apb_rsp_t;

endpackage

// File: design/iet_gate.sv
// Level gateway and pending flag for one interrupt source.
// Assumes the source line is driven by logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module iet_gate (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic src_level,
  input  wire logic claim_hit,
  input  wire logic complete_hit,
  output logic      pending
);

  logic pend_q;
  logic busy_q;

  // ----------------------------------------------------------------------
  // Pending and in-service state
  // ----------------------------------------------------------------------
  // A held level raises one request; a new one waits for completion.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (src_level && !pend_q && !busy_q) begin
      pend_q <= 1'b1; // RULE_18
    end else if (claim_hit) begin
      pend_q <= 1'b0; // RULE_10
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (claim_hit) begin
      busy_q <= 1'b1;
    end else if (complete_hit) begin
      busy_q <= 1'b0;
    end
  end

  assign pending = pend_q;

endmodule
`default_nettype wire

// File: design/iet_pick.sv
// Selects the highest-priority eligible source, lowest ID on a tie.
// Assumes bit k of elig and field k of prio_flat belong to ID k+1.
`timescale 1ns/10ps
`default_nettype none
module iet_pick #(
  parameter int N  = 52,
  parameter int PW = 3,
  parameter int IW = 6
) (
  input  wire logic [N-1:0]    elig,
  input  wire logic [N*PW-1:0] prio_flat,
  output logic [IW-1:0]        best_id,
  output logic [PW-1:0]        best_prio,
  output logic                 best_valid
);

  // ----------------------------------------------------------------------
  // Linear scan
  // ----------------------------------------------------------------------
  // Strict compare keeps the first, lower ID among equal priorities.
  always_comb begin
    best_id   = '0;
    best_prio = '0;
    for (int k = 0; k < N; k++) begin
      if (elig[k] && (prio_flat[k*PW +: PW] > best_prio)) begin
        best_prio = prio_flat[k*PW +: PW]; // RULE_16
        best_id   = IW'(k + 1);
      end
    end
    best_valid = (best_prio != '0);
  end

endmodule
`default_nettype wire

// File: verification/iet_hart_model.sv
// Hart-side model: issues APB word transfers into the interrupt block.
// Assumes one clock and a slave that raises pready some cycles into the access phase.
`timescale 1ns/10ps
`default_nettype none
module iet_hart_model (
  input  wire logic                  clk,
  input  wire iet_pkg::iet_apb_rsp_t apb_rsp,
  output iet_pkg::iet_apb_req_t      apb_req
);
  import iet_pkg::*;

  initial apb_req = '0;

  // ------------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------------
  // Whole 32-bit words only, since the bus carries no byte strobes.
  // Completion is just a write of an ID, so it uses this same path.
  // Released lines show inverted values so stale data cannot pass.
  // The wait for pready has no limit of its own; only the bench watchdog ends it.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic tmo);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err   = apb_rsp.pslverr;
    tmo   = (apb_rsp.pready !== 1'b1);
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~addr, pwdata: ~wdata};
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the interrupt enable, threshold and claim block.
// Assumes the hart model drives APB and this bench drives the source lines.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import iet_pkg::*;
  logic                 clk       = 1'b0;
  logic                 reset_n   = 1'b0;
  logic [IET_NUM_SRC:1] src_level = '0;
  iet_apb_req_t         apb_req;
  iet_apb_rsp_t         apb_rsp;
  logic                 irq;
  int                   n_errors  = 0;
  int                   checked   = 0;

  always #12.5 clk = ~clk;

  iet_top i_iet_top (.clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
                     .src_level(src_level), .machine_external_pending_flag(irq));
  iet_hart_model i_iet_hart_model (.clk(clk), .apb_rsp(apb_rsp), .apb_req(apb_req));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    logic        t;
    i_iet_hart_model.xfer(1'b1, a, d, r, e, t);
    chk({30'h0, e, t}, 32'h0, "write response");
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    logic        t;
    i_iet_hart_model.xfer(1'b0, a, 32'h0, r, e, t);
    chk({30'h0, e, t}, 32'h0, "read response");
    chk(r, exp, what);
  endtask

  // The request trails a change by two cycles at most, so four is ample.
  task automatic irq_is(input logic exp, input string what);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp}, what);
  endtask

  function automatic logic [31:0] prio_addr(input int id);
    return IET_PRIO_BASE + 32'(4 * id);
  endfunction

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    logic        t;
    rd(IET_EN_LO, 32'h0, "enable low after reset");
    rd(IET_THRESH, 32'h0, "threshold after reset");
    wr(IET_EN_LO, 32'hffff_ffff);
    rd(IET_EN_LO, 32'hffff_fffe, "enable low all ones");
    wr(IET_EN_HI, 32'hffff_ffff);
    rd(IET_EN_HI, 32'h001f_ffff, "enable high all ones");
    wr(IET_THRESH, 32'hffff_ffff);
    rd(IET_THRESH, 32'h0000_0007, "threshold all ones");
    wr(IET_THRESH, 32'h0000_0005);
    rd(IET_THRESH, 32'h0000_0005, "threshold field");
    i_iet_hart_model.xfer(1'b0, IET_EN_HI + 32'h4, 32'h0, r, e, t);
    chk(r, 32'h0, "unmapped read data");
    chk({30'h0, e, t}, 32'h2, "unmapped read error");
    wr(IET_EN_LO, 32'h0);
    wr(IET_EN_HI, 32'h0);
    wr(IET_THRESH, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_claim();
    wr(prio_addr(3), 32'h5);
    wr(prio_addr(40), 32'h5);
    wr(prio_addr(52), 32'h7);
    wr(prio_addr(10), 32'h0);
    src_level[3]  <= 1'b1;
    src_level[10] <= 1'b1;
    src_level[40] <= 1'b1;
    src_level[52] <= 1'b1;
    irq_is(1'b0, "request with nothing enabled");
    rd(IET_PEND_LO, 32'h0000_0408, "pending low");
    rd(IET_PEND_HI, 32'h0010_0100, "pending high");
    rd(IET_CLAIM, 32'h0, "claim with nothing enabled");
    wr(IET_EN_LO, 32'h0000_0408);
    wr(IET_EN_HI, 32'h0010_0100);
    irq_is(1'b1, "request at threshold zero");
    wr(IET_THRESH, 32'h7);
    irq_is(1'b0, "request at threshold seven");
    rd(IET_CLAIM, 32'd52, "claim highest priority");
    rd(IET_PEND_HI, 32'h0000_0100, "pending after claim");
    rd(IET_CLAIM, 32'd3, "claim tie lower ID");
    rd(IET_CLAIM, 32'd40, "claim next");
    rd(IET_CLAIM, 32'd0, "claim priority zero source");
    wr(IET_THRESH, 32'h5);
    wr(IET_EN_HI, 32'h0010_0000);
    wr(IET_CLAIM, 32'd40);
    rd(IET_PEND_HI, 32'h0, "completion of disabled ID");
    wr(IET_CLAIM, 32'd52);
    rd(IET_PEND_HI, 32'h0010_0000, "completion out of order");
    irq_is(1'b1, "priority seven over five");
    wr(IET_CLAIM, 32'd67);
    rd(IET_PEND_LO, 32'h0000_0400, "completion of unknown ID");
    wr(IET_CLAIM, 32'd3);
    wr(IET_THRESH, 32'h6);
    wr(IET_EN_HI, 32'h0);
    rd(IET_PEND_LO, 32'h0000_0408, "re-pend after completion");
    irq_is(1'b0, "priority five at threshold six");
    wr(IET_THRESH, 32'h4);
    irq_is(1'b1, "priority five at threshold four");
    src_level <= '0;
    $display("t_claim done");
  endtask

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_claim();
    tally_and_finish();
  end

  // The tests need well under a thousand cycles; this allows twenty times that.
  initial begin
    #(25 * 20000);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
